// file: common/vgapal_cfg.svh
`ifndef VGAPAL_CFG_SVH
`define VGAPAL_CFG_SVH
// Port addresses (low bits of legacy I/O space)
`define VGAPAL_PORT_WR      16'h03C0
`define VGAPAL_PORT_RD      16'h03C1
`define VGAPAL_PORT_STAT_M  16'h03BA
`define VGAPAL_PORT_STAT_C  16'h03DA
// Index register fields
`define VGAPAL_IDX_PAS      5
`define VGAPAL_IDX_MSB      4
// Palette entry fields
`define VGAPAL_CV_MSB       5
`define VGAPAL_NUM_ENTRIES  16
// Attribute register indices handled here
`define VGAPAL_IDX_MODE     5'h10
`define VGAPAL_IDX_CSEL     5'h14
`define VGAPAL_MODE_V54     7
// Reset values
`define VGAPAL_RST_BYTE     8'h00
`define VGAPAL_RST_IDX      6'h00
`define VGAPAL_RST_PAL      6'h00
// FIFO shape
`define VGAPAL_FIFO_DEPTH   16
`define VGAPAL_FIFO_AW      4
`endif

// file: common/vgapal_pkg.sv
package vgapal_pkg;
    typedef enum logic [1:0] {
        VGAPAL_FF_INDEX = 2'h1,
        VGAPAL_FF_DATA  = 2'h2
    } vgapal_ff_t;
endpackage

// file: hdl/vgapal_fifo.sv
`timescale 1ns/1ps
`include "vgapal_cfg.svh"
module vgapal_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = `VGAPAL_FIFO_DEPTH,
    parameter int AW    = `VGAPAL_FIFO_AW
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             sys_rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    // Full at DEPTH words held
    assign in_ready_o  = (count < (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clock_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: hdl/vgapal_attr.sv
`timescale 1ns/1ps
`include "vgapal_cfg.svh"
module vgapal_attr (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Host I/O port cycles
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    // Pixel stream in
    input  wire logic        pix_valid_i,
    output logic             pix_ready_o,
    input  wire logic [3:0]  pix_colour_i,
    input  wire logic        pix_active_i,
    input  wire logic        mode_256_i,
    input  wire logic [7:0]  overscan_colour_i,
    // Pixel stream out
    output logic             pix_valid_o,
    input  wire logic        pix_ready_i,
    output logic      [7:0]  pix_data_o,
    // Status
    output logic             display_vs_host_palette_select_o,
    output logic             toggle_data_o
);
    logic [5:0]                 attribute_index_select;
    vgapal_pkg::vgapal_ff_t     wr_toggle;
    logic [5:0]                 palette_entries_sixteen [`VGAPAL_NUM_ENTRIES];
    logic [7:0]                 attribute_mode_register;
    logic [7:0]                 colour_select_register;
    logic                       q_valid;
    logic [3:0]                 q_colour;
    logic                       q_active;
    logic                       q_m256;
    logic                       q_ready;

    function automatic logic is_port(input logic [15:0] a, input logic [15:0] p);
        return a == p;
    endfunction

    wire       wr_shared   = io_wr_i && is_port(io_addr_i, `VGAPAL_PORT_WR);
    wire       rd_data     = io_rd_i && is_port(io_addr_i, `VGAPAL_PORT_RD);
    wire       rd_status   = io_rd_i && (is_port(io_addr_i, `VGAPAL_PORT_STAT_M)
                                       || is_port(io_addr_i, `VGAPAL_PORT_STAT_C));
    wire       wr_index    = wr_shared && (wr_toggle == vgapal_pkg::VGAPAL_FF_INDEX);
    wire       wr_data     = wr_shared && (wr_toggle == vgapal_pkg::VGAPAL_FF_DATA);
    wire [4:0] attribute_register_pointer = attribute_index_select[`VGAPAL_IDX_MSB:0];
    wire       display_vs_host_palette_select = attribute_index_select[`VGAPAL_IDX_PAS];
    wire       ptr_is_pal  = attribute_register_pointer < 5'(`VGAPAL_NUM_ENTRIES);
    wire       pal_we      = wr_data && ptr_is_pal && !display_vs_host_palette_select;
    wire       mode_we     = wr_data && (attribute_register_pointer == `VGAPAL_IDX_MODE);
    wire       csel_we     = wr_data && (attribute_register_pointer == `VGAPAL_IDX_CSEL);
    wire [7:0] sel_rdata   = ptr_is_pal
                           ? {2'h0, palette_entries_sixteen[attribute_register_pointer[3:0]]}
                           : (attribute_register_pointer == `VGAPAL_IDX_MODE)
                           ? attribute_mode_register
                           : (attribute_register_pointer == `VGAPAL_IDX_CSEL)
                           ? colour_select_register : `VGAPAL_RST_BYTE;
    assign io_rdata_o = rd_data ? sel_rdata
                      : wr_toggle == vgapal_pkg::VGAPAL_FF_INDEX ? `VGAPAL_RST_BYTE
                      : {2'h0, attribute_index_select};
    assign display_vs_host_palette_select_o = display_vs_host_palette_select;
    assign toggle_data_o = (wr_toggle == vgapal_pkg::VGAPAL_FF_DATA);

    // data reads do not touch toggle
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || rd_status)
            wr_toggle <= vgapal_pkg::VGAPAL_FF_INDEX;
        else if (wr_shared)
            wr_toggle <= (wr_toggle == vgapal_pkg::VGAPAL_FF_INDEX)
                       ? vgapal_pkg::VGAPAL_FF_DATA : vgapal_pkg::VGAPAL_FF_INDEX;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            attribute_index_select <= `VGAPAL_RST_IDX;
        else if (wr_index)
            attribute_index_select <= io_wdata_i[5:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            attribute_mode_register <= `VGAPAL_RST_BYTE;
            colour_select_register  <= `VGAPAL_RST_BYTE;
        end
        else
        begin
            if (mode_we)
                attribute_mode_register <= io_wdata_i;
            if (csel_we)
                colour_select_register <= io_wdata_i;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `VGAPAL_NUM_ENTRIES; gi++)
        begin : g_pal
            always_ff @(posedge clock_i)
            begin
                if (sys_rst_i)
                    palette_entries_sixteen[gi] <= `VGAPAL_RST_PAL;
                else if (pal_we && attribute_register_pointer[3:0] == 4'(gi))
                    palette_entries_sixteen[gi] <= io_wdata_i[`VGAPAL_CV_MSB:0];
            end
        end
    endgenerate

    vgapal_fifo #(
        .WIDTH (7)
    ) u_fifo (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (pix_valid_i),
        .in_ready_o  (pix_ready_o),
        .in_data_i   ({mode_256_i, pix_active_i, pix_colour_i}),
        .out_valid_o (q_valid),
        .out_ready_i (q_ready),
        .out_data_o  ({q_m256, q_active, q_colour})
    );

    // Output stage register
    assign q_ready = !pix_valid_o || pix_ready_i;
    wire [5:0] six_bit_colour_value = palette_entries_sixteen[q_colour];
    wire       upper_pair_source_select = attribute_mode_register[`VGAPAL_MODE_V54];
    wire [1:0] out54 = upper_pair_source_select ? colour_select_register[1:0]
                                                : six_bit_colour_value[5:4];
    wire [7:0] pal_pix = q_m256 ? {4'h0, q_colour}
                       : {colour_select_register[3:2], out54, six_bit_colour_value[3:0]};
    wire [7:0] next_pix = (!display_vs_host_palette_select || !q_active)
                        ? overscan_colour_i : pal_pix;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            pix_valid_o <= 1'b0;
            pix_data_o  <= `VGAPAL_RST_BYTE;
        end
        else if (q_ready)
        begin
            pix_valid_o <= q_valid;
            if (q_valid)
                pix_data_o <= next_pix;
        end
    end

    property p_toggle_flip;
        @(posedge clock_i) disable iff (sys_rst_i)
        (wr_shared && !rd_status) |=> (toggle_data_o != $past(toggle_data_o));
    endproperty
    a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not flip");

    property p_status_reset;
        @(posedge clock_i) disable iff (sys_rst_i)
        rd_status |=> !toggle_data_o;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("status read kept toggle");

    property p_rd_keep;
        @(posedge clock_i) disable iff (sys_rst_i)
        (rd_data && !wr_shared && !rd_status) |=> $stable(toggle_data_o);
    endproperty
    a_rd_keep: assert property (p_rd_keep) else $error("data read moved toggle");

    property p_pal_lock;
        @(posedge clock_i) disable iff (sys_rst_i)
        display_vs_host_palette_select |=> $stable(palette_entries_sixteen[0]);
    endproperty
    a_pal_lock: assert property (p_pal_lock) else $error("palette changed while locked");

    property p_pal_write;
        @(posedge clock_i) disable iff (sys_rst_i)
        (pal_we && attribute_register_pointer == 5'h00)
            |=> palette_entries_sixteen[0] == $past(io_wdata_i[5:0]);
    endproperty
    a_pal_write: assert property (p_pal_write) else $error("palette write lost");

    property p_blank;
        @(posedge clock_i) disable iff (sys_rst_i)
        (q_ready && q_valid && !display_vs_host_palette_select)
            |=> pix_data_o == $past(overscan_colour_i);
    endproperty
    a_blank: assert property (p_blank) else $error("pixels shown while blanked");

    property p_upper;
        @(posedge clock_i) disable iff (sys_rst_i)
        (q_ready && q_valid && !q_m256 && display_vs_host_palette_select && q_active)
            |=> pix_data_o[7:6] == $past(colour_select_register[3:2]);
    endproperty
    a_upper: assert property (p_upper) else $error("bits 7-6 wrong");

    property p_v54;
        @(posedge clock_i) disable iff (sys_rst_i)
        (q_ready && q_valid && !q_m256 && display_vs_host_palette_select && q_active
            && upper_pair_source_select)
            |=> pix_data_o[5:4] == $past(colour_select_register[1:0]);
    endproperty
    a_v54: assert property (p_v54) else $error("bits 5-4 wrong");

    property p_index_wr;
        @(posedge clock_i) disable iff (sys_rst_i)
        wr_index |=> attribute_index_select == $past(io_wdata_i[5:0]);
    endproperty
    a_index_wr: assert property (p_index_wr) else $error("index not loaded");
endmodule

// file: test/vgapal_host_model.sv
`timescale 1ns/1ps
`include "vgapal_cfg.svh"
module vgapal_host_model (
    // Clock
    input  wire logic        clock_i,
    // Port cycles
    output logic      [15:0] io_addr_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [7:0]  io_wdata_o,
    input  wire logic [7:0]  io_rdata_i
);
    initial
    begin
        io_addr_o  = 16'h0000;
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        io_wdata_o = 8'h00;
    end
    // One strobe cycle; afterwards both strobes drop low and address and data show the inverted last value
    task automatic cycle(input logic [15:0] a, input logic w, input logic [7:0] d,
                         output logic [7:0] q);
        @(negedge clock_i);
        io_addr_o  = a;
        io_wr_o    = w;
        io_rd_o    = !w;
        io_wdata_o = d;
        @(posedge clock_i);
        q = io_rdata_i;
        @(negedge clock_i);
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        io_addr_o  = ~a;
        io_wdata_o = ~d;
    endtask
    task automatic index(input logic src, input logic [4:0] idx);
        logic [7:0] q;
        cycle(`VGAPAL_PORT_WR, 1'b1, {2'b00, src, idx}, q);
    endtask
    task automatic set_reg(input logic src, input logic [4:0] idx, input logic [7:0] d);
        logic [7:0] q;
        cycle(`VGAPAL_PORT_STAT_C, 1'b0, 8'h00, q);
        index(src, idx);
        cycle(`VGAPAL_PORT_WR, 1'b1, d, q);
    endtask
    task automatic get_reg(input logic src, input logic [4:0] idx, output logic [7:0] q);
        cycle(`VGAPAL_PORT_STAT_C, 1'b0, 8'h00, q);
        index(src, idx);
        cycle(`VGAPAL_PORT_RD, 1'b0, 8'h00, q);
    endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
`include "vgapal_cfg.svh"
module testbench;
    logic        clock_i = 1'b0;
    logic        sys_rst_i;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata_o;
    logic        pix_valid_i;
    logic        pix_ready_o;
    logic [3:0]  pix_colour_i;
    logic        pix_active_i;
    logic        mode_256_i;
    logic        pix_valid_o;
    logic        pix_ready_i;
    logic [7:0]  pix_data_o;
    logic        sel_o;
    logic        toggle_data_o;
    int          n_errors = 0;
    int          cmp_count = 0;
    always #2.5 clock_i = ~clock_i;
    vgapal_host_model u_vgapal_host_model (.clock_i(clock_i), .io_addr_o(io_addr),
        .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata_o));
    vgapal_attr u_vgapal_attr (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
        .io_rdata_o(io_rdata_o), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
        .pix_colour_i(pix_colour_i), .pix_active_i(pix_active_i), .mode_256_i(mode_256_i),
        .overscan_colour_i(8'h5A), .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i),
        .pix_data_o(pix_data_o), .display_vs_host_palette_select_o(sel_o),
        .toggle_data_o(toggle_data_o));
    task automatic wrap_up;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    function automatic logic [5:0] pal(input logic [3:0] i);
        return 6'h3F - {2'b00, i} * 6'h03;
    endfunction
    function automatic logic [7:0] expf(input logic [3:0] c, input logic v);
        logic [5:0] p;
        p = pal(c);
        return {2'b11, v ? 2'b01 : p[5:4], p[3:0]};
    endfunction
    task automatic push(input logic [3:0] c, input logic [7:0] e);
        int k;
        @(negedge clock_i);
        pix_valid_i  = 1'b1;
        pix_colour_i = c;
        @(negedge clock_i);
        pix_valid_i = 1'b0;
        for (k = 0; k < 20 && pix_valid_o !== 1'b1; k++) @(negedge clock_i);
        if (k == 20)
        begin
            n_errors++;
            wrap_up();
        end
        chk("pix_data_o", e, pix_data_o);
    endtask
    task automatic t_toggle;
        logic [7:0] q;
        chk("toggle", 8'h00, {7'h00, toggle_data_o});
        u_vgapal_host_model.index(1'b0, 5'h00);
        chk("toggle", 8'h01, {7'h00, toggle_data_o});
        u_vgapal_host_model.cycle(`VGAPAL_PORT_RD, 1'b0, 8'h00, q);
        chk("toggle", 8'h01, {7'h00, toggle_data_o});
        u_vgapal_host_model.cycle(`VGAPAL_PORT_STAT_M, 1'b0, 8'h00, q);
        chk("toggle", 8'h00, {7'h00, toggle_data_o});
        u_vgapal_host_model.set_reg(1'b0, 5'h00, 8'h00);
        chk("toggle", 8'h00, {7'h00, toggle_data_o});
    endtask
    task automatic t_palette;
        logic [7:0] q;
        for (int i = 0; i < 16; i++)
            u_vgapal_host_model.set_reg(1'b0, 5'(i), {2'b00, pal(4'(i))});
        chk("select", 8'h00, {7'h00, sel_o});
        for (int i = 0; i < 16; i++)
        begin
            u_vgapal_host_model.get_reg(1'b0, 5'(i), q);
            chk("palette", {2'b00, pal(4'(i))}, q);
        end
        push(4'h3, 8'h5A);
    endtask
    task automatic t_display;
        logic [7:0] q;
        int n;
        int m;
        n = 0;
        m = 0;
        u_vgapal_host_model.set_reg(1'b0, 5'h10, 8'h00);
        u_vgapal_host_model.set_reg(1'b0, 5'h14, 8'h0D);
        u_vgapal_host_model.set_reg(1'b1, 5'h00, 8'h00);
        chk("select", 8'h01, {7'h00, sel_o});
        u_vgapal_host_model.get_reg(1'b1, 5'h00, q);
        chk("palette0", {2'b00, pal(4'h0)}, q);
        u_vgapal_host_model.get_reg(1'b1, 5'h14, q);
        chk("colour_select", 8'h0D, q);
        pix_ready_i = 1'b0;
        for (int k = 0; k < 24; k++)
        begin
            @(negedge clock_i);
            pix_valid_i  = 1'b1;
            pix_colour_i = n[3:0];
            @(posedge clock_i);
            if (pix_ready_o === 1'b1) n++;
        end
        @(negedge clock_i);
        pix_valid_i = 1'b0;
        chk("pix_ready_o", 8'h00, {7'h00, pix_ready_o});
        // FIFO words plus the output stage
        chk("accepted", 8'(`VGAPAL_FIFO_DEPTH + 1), 8'(n));
        pix_ready_i = 1'b1;
        // Look before each edge: the held word leaves at the next one
        for (int k = 0; k < 40; k++)
        begin
            if (pix_valid_o === 1'b1)
            begin
                chk("pix_data_o", expf(m[3:0], 1'b0), pix_data_o);
                m++;
            end
            @(negedge clock_i);
        end
        chk("drained", 8'(n), 8'(m));
    endtask
    initial
    begin
        sys_rst_i    = 1'b1;
        pix_valid_i  = 1'b0;
        pix_colour_i = 4'h0;
        pix_active_i = 1'b1;
        mode_256_i   = 1'b0;
        pix_ready_i  = 1'b1;
        repeat (5) @(negedge clock_i);
        sys_rst_i = 1'b0;
        t_toggle();
        t_palette();
        t_display();
        u_vgapal_host_model.set_reg(1'b1, 5'h10, 8'h80);
        push(4'h7, expf(4'h7, 1'b1));
        // 256-colour pixels bypass the palette
        mode_256_i = 1'b1;
        push(4'h7, 8'h07);
        mode_256_i = 1'b0;
        // Border pixels show the overscan colour
        pix_active_i = 1'b0;
        push(4'h7, 8'h5A);
        pix_active_i = 1'b1;
        wrap_up();
    end
endmodule
